/* hdl/tcf_framer.sv */
// Purpose: Transmit offload framer: header template, payload window, frame stream
// Assumes: Host and payload writer run on clk_sys_i; host polls busy between control writes
// Notes: Frame bytes pass an 8-entry FIFO before the MAC side

module tcf_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_o = cnt_r != FULL;
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rp_r];
  assign level_o = cnt_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // Depth is a power of two, so pointers wrap by overflow
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || (ce_i && flush_i)) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push) mem_r[wp_r] <= in_data_i;
  end
endmodule

// Notes on behaviour
// - Reset returns every control register and state machine to its start value.
// - Host read or header memory write completes in one clock; control writes are staged; strobe high writes.
// - Send-done interrupt rises after last packet or transmit reset, held until cleared.
// - Payload port takes one byte each clock its strobe is high while fewer than 4096 bytes are held.
// - Full flag rises early so three further bytes still fit.
// - First frame byte shows before any advance; advance moves one byte.
// - Frame-available drops for a cycle after each frame's last byte.
// - Header template memory is host readable and writable as words.
// - Header length register holds the combined header byte count.
// - Frame length register holds the full frame limit.
// - Payload is cut into packets of the segment length.
// - Segment length zero sends the header template alone.
// - Working sequence number grows by segment length per packet.
// - Packet count writes add to the outstanding count.
// - Release offset write frees payload bytes below that offset.
// - Transmit reset reloads sequence, rewinds send pointer, clears frame FIFO.
// - Reset during a send waits for the current frame, drops queued packets.
// - Access-status reads nonzero while a control write is still pending.
// - A packet starts only with count nonzero and a full segment buffered.
// - IP identification starts at 32768 and stays in the upper half.
// - IP header checksum is placed in bytes 34 and 35.
// - TCP checksum is placed in bytes 50 and 51.
module tcf_framer
  import tcf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic host_we_i,
  input wire logic [13:0] host_addr_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  output logic send_done_irq_o,
  input wire logic pay_we_i,
  input wire logic [7:0] pay_data_i,
  output logic pay_full_o,
  input wire logic mac_adv_i,
  output logic mac_avail_o,
  output logic [7:0] mac_data_o
);
  logic [31:0] hmem [512];
  logic [7:0] pbuf [2**PBUF_AW];
  tcf_wreq_t stg_r;
  tcf_state_t st_r;
  tcf_beat_t beat_w;
  tcf_beat_t head_w;
  logic [1:0] acc_cnt_r;
  logic [15:0] hdr_len_r, mtu_r, seg_len_r, id_r, k_r, ip_cs_r, tcp_cs_r, pkt_cnt_r, pkt_nxt;
  logic [31:0] seq_host_r, seq_work_r, rel_off_r, wr_cnt_r, rd_off_r, ip_sum_r, tcp_sum_r;
  logic [31:0] host_rdata_r, used_w, paddr_w, tcp_fin_w;
  logic [31:0] hword_w;
  logic [15:0] flen_w, w16_w;
  logic [7:0] hraw_w, hbyte_w, byte_w;
  logic trst_pend_r, irq_r, avail_r, apply_w, busy_w, patch_w, in_hdr_w, ready_w;
  logic start_w, push_w, last_w, done_w, rst_go_w, pop_w, fifo_ready_w, fifo_valid_w;
  logic [3:0] level_w;

  assign apply_w = acc_cnt_r == 2'h1;
  assign busy_w = acc_cnt_r != 2'h0 || trst_pend_r;
  assign flen_w = hdr_len_r + seg_len_r;
  assign used_w = wr_cnt_r - rel_off_r;
  assign ready_w = (wr_cnt_r - rd_off_r) >= {16'h0000, seg_len_r};
  assign start_w = st_r == ST_IDLE && !trst_pend_r && pkt_cnt_r != 16'h0000 && ready_w;
  assign last_w = k_r == flen_w - 16'h0001;
  assign push_w = st_r == ST_SEND && fifo_ready_w;
  assign done_w = push_w && last_w;
  assign rst_go_w = st_r == ST_FLUSH && level_w == 4'h0 && !avail_r;
  assign pop_w = mac_adv_i && avail_r;
  assign pay_full_o = used_w >= FULL_LVL;
  assign host_rdata_o = host_rdata_r;
  assign send_done_irq_o = irq_r;
  assign mac_avail_o = avail_r;
  assign mac_data_o = head_w.data;

  // Host side: one-clock reads and writes, control writes staged
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      host_rdata_r <= 32'h0000_0000;
    end else if (ce_i) begin
      if (host_addr_i <= A_HMEM_LAST) host_rdata_r <= hmem[host_addr_i[8:0]];
      else if (host_addr_i == A_ACC) host_rdata_r <= {31'h0000_0000, busy_w};
      else host_rdata_r <= 32'h0000_0000;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      acc_cnt_r <= 2'h0;
      stg_r <= '0;
    end else if (ce_i) begin
      if (acc_cnt_r != 2'h0) begin
        acc_cnt_r <= acc_cnt_r - 2'h1;
      end else if (host_we_i && host_addr_i >= A_HDR_LEN) begin
        acc_cnt_r <= ACC_CYCLES;
        stg_r <= '{addr: host_addr_i, data: host_wdata_i};
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hdr_len_r <= 16'h0000;
      mtu_r <= 16'h0000;
      seg_len_r <= 16'h0000;
      seq_host_r <= 32'h0000_0000;
      rel_off_r <= 32'h0000_0000;
    end else if (ce_i && apply_w) begin
      if (stg_r.addr == A_HDR_LEN) hdr_len_r <= stg_r.data[15:0];
      else if (stg_r.addr == A_MTU) mtu_r <= stg_r.data[15:0];
      else if (stg_r.addr == A_SEG) seg_len_r <= stg_r.data[15:0];
      else if (stg_r.addr == A_SEQ) seq_host_r <= stg_r.data;
      else if (stg_r.addr == A_REL) rel_off_r <= stg_r.data;
    end
  end

  // Transmit reset request, and the send-done interrupt
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      trst_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (apply_w && stg_r.addr == A_TRST && stg_r.data[7:0] == TRST_CMD) trst_pend_r <= 1'b1;
      else if (rst_go_w) trst_pend_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      // Set wins over a clear in the same cycle
      if ((done_w && pkt_nxt == 16'h0000) || rst_go_w) irq_r <= 1'b1;
      else if (apply_w && stg_r.addr == A_IRQC) irq_r <= 1'b0;
    end
  end

  // Payload window
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_cnt_r <= 32'h0000_0000;
    end else if (ce_i && pay_we_i && used_w < PBUF_DEPTH) begin
      wr_cnt_r <= wr_cnt_r + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && pay_we_i && used_w < PBUF_DEPTH) pbuf[wr_cnt_r[PBUF_AW-1:0]] <= pay_data_i;
  end

  // Frame byte source with header patching
  assign hword_w = hmem[k_r[10:2]];
  assign hraw_w = hword_w[{~k_r[1:0], 3'b000} +: 8];
  assign in_hdr_w = k_r < hdr_len_r;
  assign paddr_w = rd_off_r + {16'h0000, k_r - hdr_len_r};
  assign byte_w = in_hdr_w ? hbyte_w : pbuf[paddr_w[PBUF_AW-1:0]];
  assign w16_w = k_r[0] ? {8'h00, byte_w} : {byte_w, 8'h00};
  assign tcp_fin_w = tcp_sum_r + PROTO_TCP + {16'h0000, flen_w - B_L4};
  always_comb begin
    patch_w = 1'b1;
    case (k_r)
      B_ID: hbyte_w = id_r[15:8];
      B_ID + 16'h0001: hbyte_w = id_r[7:0];
      B_SEQ: hbyte_w = seq_work_r[31:24];
      B_SEQ + 16'h0001: hbyte_w = seq_work_r[23:16];
      B_SEQ + 16'h0002: hbyte_w = seq_work_r[15:8];
      B_SEQ + 16'h0003: hbyte_w = seq_work_r[7:0];
      B_IPCS: hbyte_w = ip_cs_r[15:8];
      B_IPCS + 16'h0001: hbyte_w = ip_cs_r[7:0];
      B_TCPCS: hbyte_w = tcp_cs_r[15:8];
      B_TCPCS + 16'h0001: hbyte_w = tcp_cs_r[7:0];
      default: begin
        hbyte_w = hraw_w;
        patch_w = 1'b0;
      end
    endcase
  end
  // Host write wins; a patch byte colliding with it is skipped in memory only
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (host_we_i && host_addr_i <= A_HMEM_LAST) hmem[host_addr_i[8:0]] <= host_wdata_i;
      else if (push_w && in_hdr_w && patch_w) hmem[k_r[10:2]][{~k_r[1:0], 3'b000} +: 8] <= hbyte_w;
    end
  end

  // Frame sequencer: checksum pass, then stream
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
      k_r <= 16'h0000;
      ip_sum_r <= 32'h0000_0000;
      tcp_sum_r <= 32'h0000_0000;
      ip_cs_r <= 16'h0000;
      tcp_cs_r <= 16'h0000;
    end else if (ce_i) begin
      case (st_r)
        ST_IDLE: begin
          if (trst_pend_r) begin
            st_r <= ST_FLUSH;
          end else if (start_w) begin
            st_r <= ST_SUM;
            k_r <= 16'h0000;
            ip_sum_r <= 32'h0000_0000;
            tcp_sum_r <= 32'h0000_0000;
            ip_cs_r <= 16'h0000;
            tcp_cs_r <= 16'h0000;
          end
        end
        ST_SUM: begin
          if (k_r == flen_w) begin
            ip_cs_r <= ~tcf_fold(ip_sum_r);
            tcp_cs_r <= ~tcf_fold(tcp_fin_w);
            k_r <= 16'h0000;
            st_r <= ST_SEND;
          end else begin
            if (k_r >= B_IPS && k_r <= B_IPE) ip_sum_r <= ip_sum_r + {16'h0000, w16_w};
            if (k_r >= B_TCPS || (k_r >= B_SRC && k_r <= B_IPE)) begin
              tcp_sum_r <= tcp_sum_r + {16'h0000, w16_w};
            end
            k_r <= k_r + 16'h0001;
          end
        end
        ST_SEND: begin
          if (push_w) begin
            k_r <= k_r + 16'h0001;
            if (last_w) st_r <= ST_IDLE;
          end
        end
        ST_FLUSH: begin
          if (rst_go_w) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Per-packet counters
  always_comb begin
    pkt_nxt = pkt_cnt_r;
    if (apply_w && stg_r.addr == A_PKT) pkt_nxt = pkt_nxt + {8'h00, stg_r.data[7:0]};
    if (done_w) pkt_nxt = pkt_nxt - 16'h0001;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pkt_cnt_r <= 16'h0000;
      seq_work_r <= 32'h0000_0000;
      rd_off_r <= 32'h0000_0000;
      id_r <= IP_ID_INIT;
    end else if (ce_i) begin
      if (rst_go_w) begin
        pkt_cnt_r <= 16'h0000;
        seq_work_r <= seq_host_r;
        rd_off_r <= rel_off_r;
      end else begin
        pkt_cnt_r <= pkt_nxt;
        if (done_w) begin
          seq_work_r <= seq_work_r + {16'h0000, seg_len_r};
          rd_off_r <= rd_off_r + {16'h0000, seg_len_r};
          id_r <= {1'b1, id_r[14:0] + 15'h0001};
        end
      end
    end
  end

  // Frame FIFO and MAC-side availability
  assign beat_w = '{last: last_w, data: byte_w};
  tcf_fifo #(.W(9), .DEPTH(8)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .flush_i(rst_go_w),
    .in_valid_i(st_r == ST_SEND),
    .in_ready_o(fifo_ready_w),
    .in_data_i(beat_w),
    .out_valid_o(fifo_valid_w),
    .out_ready_i(pop_w),
    .out_data_o(head_w),
    .level_o(level_w)
  );
  // Bytes arrive at one per clock once streaming starts, so a small lead avoids underrun
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      avail_r <= 1'b0;
    end else if (ce_i) begin
      if (pop_w && head_w.last) avail_r <= 1'b0;
      else if (!avail_r && level_w >= FIFO_START) avail_r <= 1'b1;
    end
  end

  a_irq_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    irq_r && !(ce_i && apply_w && stg_r.addr == A_IRQC) |=> irq_r)
    else $error("send-done dropped without a clear");
  a_irq_clr: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && apply_w && stg_r.addr == A_IRQC && !done_w && !rst_go_w |=> !irq_r)
    else $error("interrupt clear had no effect");
  a_full_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && pay_we_i && !pay_full_o |=> PBUF_DEPTH - used_w >= 32'h0000_0003)
    else $error("full flag leaves no room for three bytes");
  a_frame_gap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && pop_w && head_w.last |=> !mac_avail_o)
    else $error("frame-available did not drop after a frame");
  a_first_byte: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    mac_avail_o |-> fifo_valid_w)
    else $error("frame-available without a byte presented");
  a_pkt_add: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && apply_w && stg_r.addr == A_PKT && !done_w && !rst_go_w
    |=> pkt_cnt_r == $past(pkt_cnt_r) + {8'h00, $past(stg_r.data[7:0])})
    else $error("packet count not added");
  a_seq_step: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && done_w |=> seq_work_r == $past(seq_work_r) + {16'h0000, $past(seg_len_r)})
    else $error("sequence number did not advance by segment length");
  a_start_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    st_r == ST_IDLE ##1 st_r == ST_SUM |-> $past(pkt_cnt_r) != 16'h0000 && $past(ready_w))
    else $error("packet started without count or data");
  a_id_range: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    id_r[15])
    else $error("IP identification left upper half");
  a_busy_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && host_addr_i == A_ACC && busy_w |=> host_rdata_o != 32'h0000_0000)
    else $error("access status read zero while busy");
  a_trst_load: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && rst_go_w |=> rd_off_r == $past(rel_off_r) && seq_work_r == $past(seq_host_r)
    && level_w == 4'h0 && pkt_cnt_r == 16'h0000)
    else $error("transmit reset did not reload pointers");
  a_trst_wait: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && st_r == ST_SEND && trst_pend_r && !done_w |=> st_r == ST_SEND)
    else $error("transmit reset cut a frame short");
  a_reset_idle: assert property (@(posedge clk_sys_i)
    !nrst_i |=> st_r == ST_IDLE && !irq_r && !avail_r && acc_cnt_r == 2'h0)
    else $error("reset left state active");
endmodule

/* hdl/tcf_pkg.sv */
// Purpose: Constants and types for the transmit offload framer
// Assumes: One clock for host port, payload port and MAC side
// Notes: Byte positions count from the first frame byte as zero
package tcf_pkg;
  localparam logic [13:0] A_HMEM_LAST = 14'h01ff;
  localparam logic [13:0] A_HDR_LEN = 14'h2000;
  localparam logic [13:0] A_MTU = 14'h2001;
  localparam logic [13:0] A_SEG = 14'h2002;
  localparam logic [13:0] A_SEQ = 14'h2003;
  localparam logic [13:0] A_PKT = 14'h2004;
  localparam logic [13:0] A_REL = 14'h2005;
  localparam logic [13:0] A_TRST = 14'h2006;
  localparam logic [13:0] A_IRQC = 14'h2007;
  localparam logic [13:0] A_ACC = 14'h2008;
  localparam logic [7:0] TRST_CMD = 8'h01;
  localparam int PBUF_AW = 12;
  localparam logic [31:0] PBUF_DEPTH = 32'h0000_1000;
  localparam logic [31:0] FULL_LVL = 32'h0000_0ffc;
  localparam logic [15:0] B_IPS = 16'h000e;
  localparam logic [15:0] B_IPE = 16'h0021;
  localparam logic [15:0] B_ID = 16'h0012;
  localparam logic [15:0] B_SRC = 16'h001a;
  localparam logic [15:0] B_IPCS = 16'h0022;
  localparam logic [15:0] B_L4 = 16'h0022;
  localparam logic [15:0] B_TCPS = 16'h0024;
  localparam logic [15:0] B_SEQ = 16'h0026;
  localparam logic [15:0] B_TCPCS = 16'h0032;
  localparam logic [15:0] IP_ID_INIT = 16'h8000;
  localparam logic [31:0] PROTO_TCP = 32'h0000_0006;
  localparam logic [1:0] ACC_CYCLES = 2'h3;
  localparam logic [3:0] FIFO_START = 4'h4;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tcf_beat_t;
  typedef struct packed {
    logic [13:0] addr;
    logic [31:0] data;
  } tcf_wreq_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SUM, ST_SEND, ST_FLUSH} tcf_state_t;
  function automatic logic [15:0] tcf_fold(input logic [31:0] a);
    logic [16:0] s;
    logic [16:0] t;
    s = {1'b0, a[15:0]} + {1'b0, a[31:16]};
    t = {1'b0, s[15:0]} + {16'h0000, s[16]};
    return t[15:0];
  endfunction
endpackage

/* verification/tcf_framer_tb_top.sv */
// Purpose: Self-checking bench for the transmit offload framer
// Assumes: All ports on clk_sys_i; inputs change 1 ns after the rising edge
// Notes: Header of 54 bytes, byte b of the template is b xor 0x5a
module tcf_framer_tb_top;
  import tcf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, ce, we, irq, pwe, full, adv, avail;
  logic [13:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] pdata, mdata;
  logic [3:0] stall;
  int nbytes, frames, err_count, checks_done;
  tcf_framer DUT (.clk_sys_i(clk), .nrst_i(nrst), .ce_i(ce), .host_we_i(we),
    .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata), .send_done_irq_o(irq),
    .pay_we_i(pwe), .pay_data_i(pdata), .pay_full_o(full), .mac_adv_i(adv),
    .mac_avail_o(avail), .mac_data_o(mdata));
  tcf_mac_model mac (.clk_sys_i(clk), .avail_i(avail), .data_i(mdata), .stall_i(stall),
    .adv_o(adv), .nbytes_o(nbytes), .frames_o(frames));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] pay_byte(input int n);
    return n[7:0] ^ 8'h33;
  endfunction
  task automatic host_rd(input logic [13:0] a, output logic [31:0] d);
    @(posedge clk) #1;
    we = 1'b0;
    addr = a;
    @(posedge clk) #1;
    d = rdata;
  endtask
  task automatic host_wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] r;
    @(posedge clk) #1;
    we = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    we = 1'b0;
    if (a >= A_HDR_LEN) begin
      host_rd(A_ACC, r);
      check({31'h0, r != 32'h0}, 32'h1, "busy after write");
      for (int i = 0; i < 300 && r !== 32'h0; i++) host_rd(A_ACC, r);
      if (r !== 32'h0) begin
        check(r, 32'h0, "busy never cleared");
        summarize();
      end
    end
  endtask
  task automatic pay_wr(input int off, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1;
      pwe = 1'b1;
      pdata = pay_byte(off + i);
    end
    @(posedge clk) #1;
    pwe = 1'b0;
    pdata = ~pdata;
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 5000 && frames != n; i++) @(posedge clk);
    if (frames != n) begin
      check(frames, n, "frame wait ran out");
      summarize();
    end
  endtask
  task automatic chk_frame(input int base, input int seg, input logic [31:0] seq,
                           input logic [15:0] id, input int off);
    logic [7:0] e;
    logic [31:0] w, s_ip, s_tcp;
    s_ip = 32'h0;
    // Pseudo-header: protocol 6 plus length from byte 34 (B_L4) on
    s_tcp = 32'd26 + 32'(seg);
    check(nbytes - base, 54 + seg, "frame length");
    for (int b = 0; b < 54 + seg; b++) begin
      w = b[0] ? {24'h0, mac.cap[base+b]} : {16'h0, mac.cap[base+b], 8'h0};
      if (b >= 14 && b <= 35) s_ip += w;
      if ((b >= 26 && b <= 33) || b >= 36) s_tcp += w;
      e = (b < 54) ? (b[7:0] ^ 8'h5a) : pay_byte(off + b - 54);
      if (b == 18 || b == 19) e = id[8*(19-b) +: 8];
      if (b >= 38 && b <= 41) e = seq[8*(41-b) +: 8];
      if (b != 34 && b != 35 && b != 50 && b != 51)
        check(mac.cap[base+b], e, "frame byte");
    end
    // A correct ones-complement sum including its checksum folds to all ones
    s_ip = {16'h0, s_ip[15:0]} + {16'h0, s_ip[31:16]};
    s_ip = {16'h0, s_ip[15:0]} + {16'h0, s_ip[31:16]};
    s_tcp = {16'h0, s_tcp[15:0]} + {16'h0, s_tcp[31:16]};
    s_tcp = {16'h0, s_tcp[15:0]} + {16'h0, s_tcp[31:16]};
    check(s_ip, 32'h0000_ffff, "IP checksum");
    check(s_tcp, 32'h0000_ffff, "TCP checksum");
  endtask
  task automatic t_reset();
    check(rdata, 32'h0, "rdata in reset");
    check({avail, irq, full}, 32'h0, "flags in reset");
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [31:0] r;
    for (int k = 0; k < 14; k++)
      host_wr(k[13:0], {8'(4*k), 8'(4*k+1), 8'(4*k+2), 8'(4*k+3)} ^ 32'h5a5a_5a5a);
    host_wr(A_HMEM_LAST, 32'h1234_5678);
    host_rd(14'h000d, r);
    check(r, 32'h3435_3637 ^ 32'h5a5a_5a5a, "header word 13");
    host_rd(A_HMEM_LAST, r);
    check(r, 32'h1234_5678, "header last word");
    host_rd(14'h0200, r);
    check(r, 32'h0, "unmapped read");
    host_rd(A_HDR_LEN, r);
    check(r, 32'h0, "write-only read");
    $display("test regs done");
  endtask
  task automatic t_header_only();
    host_wr(A_HDR_LEN, 32'd54);
    host_wr(A_MTU, 32'd1554);
    host_wr(A_SEG, 32'h0);
    host_wr(A_SEQ, 32'h1000_0000);
    host_wr(A_TRST, 32'h1);
    check(irq, 1'b1, "irq after reset");
    host_wr(A_IRQC, 32'h0);
    check(irq, 1'b0, "irq cleared");
    host_wr(A_PKT, 32'h1);
    wait_frames(1);
    chk_frame(0, 0, 32'h1000_0000, IP_ID_INIT, 0);
    check(irq, 1'b1, "irq after last");
    host_wr(A_IRQC, 32'hffff_ffff);
    $display("test header only done");
  endtask
  task automatic t_payload();
    stall = 4'h3;
    host_wr(A_SEG, 32'd200);
    host_wr(A_TRST, 32'h1);
    host_wr(A_IRQC, 32'h0);
    pay_wr(0, 200);
    host_wr(A_PKT, 32'h1);
    host_wr(A_PKT, 32'h1);
    wait_frames(2);
    chk_frame(54, 200, 32'h1000_0000, 16'h8001, 0);
    check(irq, 1'b0, "irq with packet left");
    repeat (600) @(posedge clk);
    check(frames, 2, "held without data");
    pay_wr(200, 200);
    wait_frames(3);
    chk_frame(308, 200, 32'h1000_00c8, 16'h8002, 200);
    check(irq, 1'b1, "irq after second");
    host_wr(A_IRQC, 32'h0);
    $display("test payload done");
  endtask
  task automatic t_full();
    pay_wr(400, 3691);
    check(full, 1'b0, "full below level");
    pay_wr(4091, 1);
    check(full, 1'b1, "full at level");
    pay_wr(4092, 3);
    check(full, 1'b1, "full after extra");
    // A byte offered while the enable is low must not be counted
    ce = 1'b0;
    pay_wr(4095, 1);
    ce = 1'b1;
    host_wr(A_REL, 32'd4);
    check(full, 1'b0, "byte taken with enable low");
    host_wr(A_REL, 32'd4000);
    check(full, 1'b0, "full after release");
    check(frames, 3, "no frame without count");
    $display("test full done");
  endtask
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    we = 1'b0;
    addr = 14'h0;
    wdata = 32'h0;
    pwe = 1'b0;
    pdata = 8'h0;
    stall = 4'h5;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    #1;
    t_reset();
    nrst = 1'b1;
    t_regs();
    t_header_only();
    t_payload();
    t_full();
    summarize();
  end
endmodule

/* verification/tcf_mac_model.sv */
// Purpose: MAC-side frame reader model for the framer bench
// Assumes: A byte is taken on each edge with advance and available high
// Notes: stall_i sets how many cycles the reader waits before taking a frame
module tcf_mac_model (
  input wire logic clk_sys_i,
  input wire logic avail_i,
  input wire logic [7:0] data_i,
  input wire logic [3:0] stall_i,
  output logic adv_o,
  output int nbytes_o,
  output int frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cap [0:1023];
  logic go_r = 1'b0;
  logic [3:0] wait_r = 4'h0;
  int nbytes_r = 0;
  int frames_r = 0;
  // Advance falls in the same cycle as available
  assign adv_o = go_r & avail_i;
  assign nbytes_o = nbytes_r;
  assign frames_o = frames_r;
  always @(posedge clk_sys_i) begin
    if (adv_o) begin
      cap[nbytes_r % 1024] <= data_i;
      nbytes_r <= nbytes_r + 1;
    end
    // Once started, advance stays high until the frame ends
    if (!avail_i) begin
      go_r <= 1'b0;
      wait_r <= 4'h0;
      if (go_r) frames_r <= frames_r + 1;
    end else if (!go_r) begin
      if (wait_r >= stall_i) go_r <= 1'b1;
      else wait_r <= wait_r + 4'h1;
    end
  end
endmodule
